// *** asc_pkg.sv ***
// Constants, types and addresses shared by the serial transceiver core
// Contract
// - Copy each received character into receive holding
// - Overrun discards new character, holding unchanged
// - Receive holding read-only; shifter hidden
// - Transmit holding write starts transmission; readable
// - Shifter loads after write or in the same cycle as done
// - Shifter load and bits on base clock
// - Mode resets 01, bit-wise writes, refresh harmless
// - Power clear gates clock, resets internal logic
// - Power off: output high, input seen high
// - Baud output active second base clock after power
// - Enable clears reset their direction's circuitry
// - Parity select: none, zero, odd, even
// - Zero parity never flags parity error
// - Length bit selects seven or eight data
// - Transmit one/two stops; receive checks one
// - Routing bit picks error or done interrupt
// - Low input at enable begins reception
// - Buffer-full sets on write, clears on load
package asc_pkg;
  localparam logic [15:0] MODE_ADDR    = 16'hff90;
  localparam logic [15:0] RXHOLD_ADDR  = 16'hff92;
  localparam logic [15:0] ERRSTAT_ADDR = 16'hff93;
  localparam logic [15:0] TXHOLD_ADDR  = 16'hff94;
  localparam logic [15:0] TXSTAT_ADDR  = 16'hff95;

  localparam logic [7:0]  MODE_RESET = 8'h01;
  localparam logic [7:0]  HOLD_RESET = 8'hff;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  localparam int POWER_BIT = 7;
  localparam int TXEN_BIT  = 6;
  localparam int RXEN_BIT  = 5;
  localparam int PAR_HI    = 4;
  localparam int PAR_LO    = 3;
  localparam int CLEN_BIT  = 2;
  localparam int STOPS_BIT = 1;
  localparam int ROUTE_BIT = 0;

  localparam int PARERR_BIT  = 2;
  localparam int FRAMERR_BIT = 1;
  localparam int OVERRUN_BIT = 0;
  localparam int TXBF_BIT    = 1;
  localparam int TXSF_BIT    = 0;

  localparam int POWER_DELAY = 2;
  localparam int MIN_DIVISOR = 8;
  localparam int FIFO_DEPTH  = 16;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } asc_parity_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_DATA   = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP   = 3'h6
  } asc_state_t;
endpackage

// *** asc_fifo_if.sv ***
// Valid/ready carrier between the receive path and its FIFO
`timescale 1ns/100ps
interface asc_fifo_if #(parameter int WIDTH = 8);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;
  modport producer (output inValid, output inData, output outReady,
                    input inReady, input outValid, input outData);
  modport storage  (input inValid, input inData, input outReady,
                    output inReady, output outValid, output outData);
endinterface

// *** asc_fifo.sv ***
// Receive character FIFO with valid/ready on both sides
`timescale 1ns/100ps
module asc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic     clock,
  input wire logic     rst,
  asc_fifo_if.storage  port
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : gBadDepth
      $error("asc_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  logic             empty;
  logic             full;

  assign empty         = wrPtr_reg == rdPtr_reg;
  assign full          = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign port.inReady  = !full;
  assign port.outValid = !empty;
  assign port.outData  = mem[rdPtr_reg[AW-1:0]];

  always_ff @(posedge clock)
  begin
    if (port.inValid && !full)
      mem[wrPtr_reg[AW-1:0]] <= port.inData;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end
    else
    begin
      if (port.inValid && !full)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (port.outReady && !empty)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end

  a_fifo_no_overfill: assert property (@(posedge clock) disable iff (rst)
    full && !(port.outReady && !empty) |=> $stable(wrPtr_reg))
    else $error("FIFO pointer moved while full");
endmodule

// *** asc_core.sv ***
// Asynchronous serial transceiver core: holding, shifters and mode register
`timescale 1ns/100ps
module asc_core (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrMask,
  input  wire logic [7:0]  wrData,
  input  wire logic        rdEn,
  output logic      [7:0]  rdData,
  input  wire logic        serialIn,
  output logic             serialOut,
  input  wire logic        msbFirst,
  input  wire logic [7:0]  baudDivisor,
  output logic             transmitDone,
  output logic             receiveDone,
  output logic             receiveError
);
  import asc_pkg::*;

  logic [7:0]             mode_reg;
  logic [POWER_DELAY-1:0] powerDly_reg;
  logic                   power, txOn, rxOn, baudOn, inView;
  asc_parity_t            parSel;
  logic [7:0]             bitLen;
  logic [7:0]             txHold_reg, rxHold_reg, errStat_reg;
  logic                   txFull_reg, rxFull_reg, txBusy_reg;
  asc_state_t             txState_reg, rxState_reg;
  logic [7:0]             txCnt_reg, rxCnt_reg, txSh_reg, rxSh_reg;
  logic [2:0]             txIdx_reg, rxIdx_reg;
  logic                   txPar_reg, rxPar_reg, txStop2_reg, rxParErr_reg;
  logic                   txLoad, txWrite, rxFinish, rxFrameErr, rxAnyErr;
  logic [7:0]             txMasked, rxFinal;
  logic [2:0]             lastIdx;

  asc_fifo_if #(.WIDTH(8)) rxq ();

  asc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uRxFifo (
    .clock (clock),
    .rst   (rst || !power),
    .port  (rxq)
  );

  assign power   = mode_reg[POWER_BIT];
  assign txOn    = power && mode_reg[TXEN_BIT];
  assign rxOn    = power && mode_reg[RXEN_BIT];
  assign parSel  = asc_parity_t'(mode_reg[PAR_HI:PAR_LO]);
  assign bitLen  = (baudDivisor < 8'(MIN_DIVISOR)) ? 8'(MIN_DIVISOR) : baudDivisor;
  assign lastIdx = mode_reg[CLEN_BIT] ? 3'h7 : 3'h6;
  assign baudOn  = power && powerDly_reg[POWER_DELAY-1];
  // Receiver sees an idle line while powered down
  assign inView  = power ? serialIn : 1'b1;
  assign txWrite = wrEn && addr == TXHOLD_ADDR;

  // Register port; partial-mask writes give bit-wise access
  always_ff @(posedge clock)
  begin
    if (rst)
      mode_reg <= MODE_RESET;
    else if (wrEn && addr == MODE_ADDR)
      mode_reg <= (mode_reg & ~wrMask) | (wrData & wrMask);
  end

  // Baud divider output only after two base clocks of power
  always_ff @(posedge clock)
  begin
    if (rst || !power)
      powerDly_reg <= '0;
    else
      powerDly_reg <= {powerDly_reg[POWER_DELAY-2:0], 1'b1};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rdData <= ZERO_BYTE;
    else if (rdEn)
    begin
      case (addr)
        MODE_ADDR:    rdData <= mode_reg;
        RXHOLD_ADDR:  rdData <= rxHold_reg;
        ERRSTAT_ADDR: rdData <= errStat_reg;
        TXHOLD_ADDR:  rdData <= txHold_reg;
        TXSTAT_ADDR:  rdData <= {6'h00, txFull_reg, txBusy_reg};
        default:      rdData <= ZERO_BYTE;
      endcase
    end
  end

  // Transmit holding; a write while full is undefined for software
  always_ff @(posedge clock)
  begin
    if (rst)
      txHold_reg <= HOLD_RESET;
    else if (txWrite)
      txHold_reg <= wrData;
  end

  always_ff @(posedge clock)
  begin
    if (rst || !txOn)
      txFull_reg <= 1'b0;
    else if (txWrite)
      txFull_reg <= 1'b1;
    else if (txLoad)
      txFull_reg <= 1'b0;
  end

  assign txLoad = baudOn && txFull_reg && (txState_reg == ST_IDLE ||
                  (txState_reg == ST_STOP && txCnt_reg == 8'h00 && (txStop2_reg || !mode_reg[STOPS_BIT])));
  assign txMasked = mode_reg[CLEN_BIT] ? txHold_reg : (msbFirst ? (txHold_reg & 8'hfe) : (txHold_reg & 8'h7f));

  // Transmit frame; one clock period stands for one base clock tick
  always_ff @(posedge clock)
  begin
    if (rst || !txOn)
    begin
      txState_reg  <= ST_IDLE;
      serialOut    <= 1'b1;
      txSh_reg     <= HOLD_RESET;
      txCnt_reg    <= 8'h00;
      txIdx_reg    <= 3'h0;
      txPar_reg    <= 1'b0;
      txStop2_reg  <= 1'b0;
      txBusy_reg   <= 1'b0;
      transmitDone <= 1'b0;
    end
    else
    begin
      transmitDone <= 1'b0;
      if (txLoad)
      begin
        // Reload ends the previous frame, so done pulses in the same cycle as the load
        transmitDone <= txState_reg == ST_STOP;
        txState_reg  <= ST_START;
        txSh_reg     <= txMasked;
        txPar_reg    <= ^txMasked;
        serialOut    <= 1'b0;
        txCnt_reg    <= bitLen - 8'h01;
        txBusy_reg   <= 1'b1;
      end
      else if (txState_reg != ST_IDLE && baudOn)
      begin
        if (txCnt_reg != 8'h00)
          txCnt_reg <= txCnt_reg - 8'h01;
        else
        begin
          txCnt_reg <= bitLen - 8'h01;
          case (txState_reg)
            ST_START:
            begin
              txState_reg <= ST_DATA;
              txIdx_reg   <= 3'h0;
              serialOut   <= msbFirst ? txSh_reg[7] : txSh_reg[0];
              txSh_reg    <= msbFirst ? {txSh_reg[6:0], 1'b0} : {1'b0, txSh_reg[7:1]};
            end
            ST_DATA:
            begin
              if (txIdx_reg == lastIdx)
              begin
                txState_reg <= (parSel == PAR_NONE) ? ST_STOP : ST_PARITY;
                txStop2_reg <= 1'b0;
                case (parSel)
                  PAR_ZERO: serialOut <= 1'b0;
                  PAR_ODD:  serialOut <= ~txPar_reg;
                  PAR_EVEN: serialOut <= txPar_reg;
                  default:  serialOut <= 1'b1;
                endcase
              end
              else
              begin
                txIdx_reg <= txIdx_reg + 3'h1;
                serialOut <= msbFirst ? txSh_reg[7] : txSh_reg[0];
                txSh_reg  <= msbFirst ? {txSh_reg[6:0], 1'b0} : {1'b0, txSh_reg[7:1]};
              end
            end
            ST_PARITY:
            begin
              txState_reg <= ST_STOP;
              serialOut   <= 1'b1;
            end
            ST_STOP:
            begin
              if (mode_reg[STOPS_BIT] && !txStop2_reg)
                txStop2_reg <= 1'b1;
              else
              begin
                txState_reg  <= ST_IDLE;
                txBusy_reg   <= 1'b0;
                transmitDone <= 1'b1;
              end
            end
            default: txState_reg <= ST_IDLE;
          endcase
        end
      end
    end
  end

  assign rxFinish   = rxState_reg == ST_STOP && rxCnt_reg == 8'h00 && baudOn;
  assign rxFrameErr = rxFinish && !inView;
  assign rxAnyErr   = rxFrameErr || rxParErr_reg || (rxFinish && !rxq.inReady);

  always_comb
  begin
    if (mode_reg[CLEN_BIT])
      rxFinal = rxSh_reg;
    else if (msbFirst)
      rxFinal = {rxSh_reg[6:0], 1'b0};
    else
      rxFinal = {1'b0, rxSh_reg[7:1]};
  end

  // Full FIFO refuses the character: it is dropped, holding untouched
  assign rxq.inValid  = rxFinish && rxOn;
  assign rxq.inData   = rxFinal;
  assign rxq.outReady = !rxFull_reg;

  always_ff @(posedge clock)
  begin
    if (rst || !rxOn)
    begin
      rxState_reg  <= ST_IDLE;
      rxSh_reg     <= HOLD_RESET;
      rxCnt_reg    <= 8'h00;
      rxIdx_reg    <= 3'h0;
      rxPar_reg    <= 1'b0;
      rxParErr_reg <= 1'b0;
    end
    else if (baudOn)
    begin
      if (rxState_reg == ST_IDLE)
      begin
        // Level test also catches a line already low at enable
        if (!inView)
        begin
          rxState_reg <= ST_START;
          rxCnt_reg   <= {1'b0, bitLen[7:1]};
        end
      end
      else if (rxCnt_reg != 8'h00)
        rxCnt_reg <= rxCnt_reg - 8'h01;
      else
      begin
        rxCnt_reg <= bitLen - 8'h01;
        case (rxState_reg)
          ST_START:
          begin
            rxState_reg  <= inView ? ST_IDLE : ST_DATA;
            rxIdx_reg    <= 3'h0;
            rxPar_reg    <= 1'b0;
            rxParErr_reg <= 1'b0;
          end
          ST_DATA:
          begin
            rxSh_reg  <= msbFirst ? {rxSh_reg[6:0], inView} : {inView, rxSh_reg[7:1]};
            rxPar_reg <= rxPar_reg ^ inView;
            rxIdx_reg <= rxIdx_reg + 3'h1;
            if (rxIdx_reg == lastIdx)
              rxState_reg <= (parSel == PAR_NONE) ? ST_STOP : ST_PARITY;
          end
          ST_PARITY:
          begin
            rxState_reg <= ST_STOP;
            // Zero parity is taken but never judged
            case (parSel)
              PAR_ODD:  rxParErr_reg <= !(rxPar_reg ^ inView);
              PAR_EVEN: rxParErr_reg <= rxPar_reg ^ inView;
              default:  rxParErr_reg <= 1'b0;
            endcase
          end
          default: rxState_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Holding drains the FIFO; write attempts never reach it
  always_ff @(posedge clock)
  begin
    if (rst || !power)
    begin
      rxHold_reg <= HOLD_RESET;
      rxFull_reg <= 1'b0;
    end
    else if (!rxFull_reg && rxq.outValid)
    begin
      rxHold_reg <= rxq.outData;
      rxFull_reg <= 1'b1;
    end
    else if (rdEn && addr == RXHOLD_ADDR)
      rxFull_reg <= 1'b0;
  end

  // Error flags: new error wins over the clearing read
  always_ff @(posedge clock)
  begin
    if (rst || !power)
      errStat_reg <= ZERO_BYTE;
    else if (rxFinish && rxOn)
    begin
      if (rdEn && addr == ERRSTAT_ADDR)
        errStat_reg <= {5'h00, rxParErr_reg, rxFrameErr, !rxq.inReady};
      else
        errStat_reg <= errStat_reg | {5'h00, rxParErr_reg, rxFrameErr, !rxq.inReady};
    end
    else if (rdEn && addr == ERRSTAT_ADDR)
      errStat_reg <= ZERO_BYTE;
  end

  always_ff @(posedge clock)
  begin
    if (rst || !rxOn)
    begin
      receiveDone  <= 1'b0;
      receiveError <= 1'b0;
    end
    else
    begin
      receiveDone  <= rxFinish && (!rxAnyErr || mode_reg[ROUTE_BIT]);
      receiveError <= rxFinish && rxAnyErr && !mode_reg[ROUTE_BIT];
    end
  end

  a_mode_reset_value: assert property (@(posedge clock) rst |=> mode_reg == MODE_RESET)
    else $error("Mode register did not reset to 01");
  a_power_line_idle: assert property (@(posedge clock) disable iff (rst)
    !power |=> serialOut && rxState_reg == ST_IDLE)
    else $error("Line not idle while powered down");
  a_baud_two_clocks: assert property (@(posedge clock) disable iff (rst)
    $rose(power) |-> !baudOn ##1 !baudOn)
    else $error("Baud output active too early");
  a_baud_needs_power: assert property (@(posedge clock) disable iff (rst)
    baudOn |-> power && $past(power, 2))
    else $error("Baud output without two powered clocks");
  a_tx_write_starts: assert property (@(posedge clock) disable iff (rst)
    txWrite && txOn && baudOn && !txFull_reg && txState_reg == ST_IDLE && mode_reg == $past(mode_reg)
    |=> txFull_reg ##1 (txState_reg == ST_START && !txFull_reg && !serialOut))
    else $error("Transmit write did not start a frame");
  a_rx_holding_ro: assert property (@(posedge clock) disable iff (rst || !power)
    wrEn && addr == RXHOLD_ADDR && (rxFull_reg || !rxq.outValid) |=> $stable(rxHold_reg))
    else $error("Receive holding changed by a write");
  a_overrun_flag: assert property (@(posedge clock) disable iff (rst || !power)
    rxFinish && rxOn && !rxq.inReady |=> errStat_reg[OVERRUN_BIT] && receiveError != mode_reg[ROUTE_BIT])
    else $error("Overrun not flagged");
  a_zero_par_quiet: assert property (@(posedge clock) disable iff (rst)
    rxFinish && parSel != PAR_ODD && parSel != PAR_EVEN |-> !rxParErr_reg)
    else $error("Parity error without odd or even parity");
  a_route_select: assert property (@(posedge clock) disable iff (rst || !rxOn)
    rxFinish && rxAnyErr |=> receiveError != receiveDone && receiveDone == $past(mode_reg[ROUTE_BIT]))
    else $error("Error interrupt routed wrongly");
endmodule

// *** asc_remote_node.sv ***
// Far-end serial node: sends frames on demand and captures frames it sees
`timescale 1ns/100ps
module asc_remote_node (
  input  wire logic       clock,
  input  wire logic       lineIn,
  output logic            lineOut,
  input  wire logic [7:0] bitTime,
  input  wire logic [3:0] frameLen
);
  logic [11:0] got[$];
  logic [11:0] shifter;

  // Idle line sits high; enabling the receiver is only safe then
  initial lineOut = 1'b1;

  // Called at a falling edge; bits[0] goes first after the start bit
  task automatic send(input logic [11:0] bits, input int n);
    lineOut = 1'b0;
    repeat (bitTime) @(negedge clock);
    for (int i = 0; i < n; i++)
    begin
      lineOut = bits[i];
      repeat (bitTime) @(negedge clock);
    end
    // Last bit is a stop bit, so the line is already left idle high
  endtask

  // Mid-bit sampling; only the first stop bit is captured
  always
  begin
    @(negedge lineIn);
    shifter = '0;
    repeat (bitTime / 2) @(negedge clock);
    for (int i = 0; i < frameLen; i++)
    begin
      repeat (bitTime) @(negedge clock);
      shifter[i] = lineIn;
    end
    got.push_back(shifter);
  end
endmodule

// *** test_async_serial_core_buffers_mode.sv ***
// Self-checking bench for the serial transceiver core
`timescale 1ns/100ps
module test_async_serial_core_buffers_mode;
  import asc_pkg::*;
  logic        clock, rst, wrEn, rdEn, msbFirst, serialIn, serialOut;
  logic        transmitDone, receiveDone, receiveError;
  logic [15:0] addr;
  logic [7:0]  wrMask, wrData, rdData, baudDivisor, mode, d1, d2, h, v;
  logic [3:0]  frameLen;
  int          err_count = 0, n_checks = 0, seed = 15, cycles = 0;
  int          doneCnt = 0, errCnt = 0, txCnt = 0, d0, e0;

  asc_core DUT (.clock(clock), .rst(rst), .addr(addr), .wrEn(wrEn), .wrMask(wrMask), .wrData(wrData),
    .rdEn(rdEn), .rdData(rdData), .serialIn(serialIn), .serialOut(serialOut), .msbFirst(msbFirst),
    .baudDivisor(baudDivisor), .transmitDone(transmitDone), .receiveDone(receiveDone),
    .receiveError(receiveError));
  asc_remote_node far (.clock(clock), .lineIn(serialOut), .lineOut(serialIn), .bitTime(baudDivisor),
    .frameLen(frameLen));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(negedge clock)
  begin
    cycles++;
    doneCnt += (receiveDone === 1'b1);
    errCnt += (receiveError === 1'b1);
    txCnt += (transmitDone === 1'b1);
    // Ceiling well above the expected run of some 7500 cycles
    if (cycles == 60000)
    begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [11:0] frame_of(logic [7:0] d, logic [7:0] m, logic msb);
    logic [11:0] f;
    int          n;
    logic        ones;
    f = '0;
    ones = 1'b0;
    n = m[CLEN_BIT] ? 8 : 7;
    for (int i = 0; i < n; i++)
    begin
      f[i] = msb ? d[7 - i] : d[i];
      ones ^= f[i];
    end
    if (m[PAR_HI:PAR_LO] != 2'h0)
    begin
      f[n] = (m[PAR_HI:PAR_LO] == 2'h1) ? 1'b0 : (m[PAR_HI:PAR_LO] == 2'h2) ? ~ones : ones;
      n++;
    end
    f[n] = 1'b1;
    return f;
  endfunction

  function automatic logic [3:0] len_of(logic [7:0] m);
    return 4'(m[CLEN_BIT] ? 9 : 8) + 4'(m[PAR_HI:PAR_LO] != 2'h0);
  endfunction

  function automatic logic [7:0] rx_of(logic [7:0] d, logic [7:0] m, logic msb);
    return m[CLEN_BIT] ? d : msb ? {d[7:1], 1'b0} : {1'b0, d[6:0]};
  endfunction

  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
    @(negedge clock);
    addr = a;
    wrData = d;
    wrMask = m;
    wrEn = 1'b1;
    @(negedge clock);
    wrEn = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    rdEn = 1'b1;
    @(negedge clock);
    rdEn = 1'b0;
    d = rdData;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    rd(a, d);
    check({4'h0, d}, {4'h0, e}, what);
  endtask

  // Enables off while the frame settings change, then on again
  task automatic set_mode(input logic [7:0] m);
    wr(MODE_ADDR, 8'h00, 8'h60);
    wr(MODE_ADDR, m & 8'h9f);
    wr(MODE_ADDR, m);
    frameLen = len_of(m);
  endtask

  task automatic rx_frame(input logic [11:0] bits);
    far.send(bits, 32'(frameLen));
    repeat (3) @(negedge clock);
    rd(RXHOLD_ADDR, h);
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    {rst, wrEn, rdEn, addr, wrMask, wrData, msbFirst, frameLen} = {1'b1, 35'h0, 4'h8};
    baudDivisor = 8'h08;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    rdc(MODE_ADDR, MODE_RESET, "mode reset");
    rdc(RXHOLD_ADDR, HOLD_RESET, "rx holding reset");
    rdc(16'hff9f, ZERO_BYTE, "unmapped read");
    check(12'(serialOut), 12'h001, "line idle unpowered");
    wr(MODE_ADDR, 8'h80);
    wr(MODE_ADDR, 8'hff, 8'h40);
    rdc(MODE_ADDR, 8'hc0, "bit write sets");
    wr(MODE_ADDR, 8'h00, 8'h40);
    rdc(MODE_ADDR, 8'h80, "bit write clears");
    d2 = 8'h3c;
    wr(TXHOLD_ADDR, d2);
    rdc(TXSTAT_ADDR, ZERO_BYTE, "no full flag while disabled");
    rdc(TXHOLD_ADDR, 8'h3c, "tx holding readable");
    // Every parity code, both lengths, both stop counts
    for (int k = 0; k < 16; k++)
    begin
      mode = {3'b111, 4'(k), 1'b0};
      msbFirst = 1'($random(seed));
      baudDivisor = 8'h08 + 8'($random(seed) & 3);
      set_mode(mode);
      // Rewriting the holding with the value it already has is not allowed mid-run
      d1 = 8'($random(seed));
      d1 = (d1 == d2) ? ~d1 : d1;
      d2 = 8'($random(seed));
      d2 = (d2 == d1) ? ~d2 : d2;
      wr(TXHOLD_ADDR, d1);
      for (int t = 0; t < 40; t++)
      begin
        rd(TXSTAT_ADDR, v);
        if (v[TXBF_BIT] === 1'b0)
          break;
      end
      wr(TXHOLD_ADDR, d2);
      rdc(TXSTAT_ADDR, 8'h03, "second char waits");
      for (int t = 0; t < 600 && far.got.size() < 2; t++)
        @(negedge clock);
      check(far.got.size() > 0 ? far.got.pop_front() : 12'hfff, frame_of(d1, mode, msbFirst), "frame 1");
      check(far.got.size() > 0 ? far.got.pop_front() : 12'hfff, frame_of(d2, mode, msbFirst), "frame 2");
      d1 = 8'($random(seed));
      rx_frame(frame_of(d1, mode, msbFirst));
      check({4'h0, h}, {4'h0, rx_of(d1, mode, msbFirst)}, "received char");
      repeat (24) @(negedge clock);
    end
    check(12'(txCnt), 12'd32, "done pulses");
    check(12'(doneCnt), 12'd16, "receive pulses");
    msbFirst = 1'b0;
    set_mode(8'hf0);
    {d0, e0} = {doneCnt, errCnt};
    rx_frame(frame_of(8'h55, 8'hf0, 1'b0) ^ 12'h080);
    check(12'(errCnt - e0), 12'h001, "error pulse");
    check(12'(doneCnt - d0), 12'h000, "no done on error");
    rdc(ERRSTAT_ADDR, 8'h04, "parity flag");
    rdc(ERRSTAT_ADDR, ZERO_BYTE, "flag cleared by read");
    wr(RXHOLD_ADDR, ~h);
    rdc(RXHOLD_ADDR, h, "rx holding not writable");
    set_mode(8'hf1);
    {d0, e0} = {doneCnt, errCnt};
    rx_frame(frame_of(8'h2a, 8'hf1, 1'b0) ^ 12'h080);
    check(12'(doneCnt - d0), 12'h001, "routed done");
    check(12'(errCnt - e0), 12'h000, "no error pulse routed");
    rdc(ERRSTAT_ADDR, 8'h04, "routed parity flag");
    set_mode(8'he8);
    e0 = errCnt;
    rx_frame(frame_of(8'h13, 8'he8, 1'b0) ^ 12'h080);
    check(12'(errCnt - e0), 12'h000, "zero parity unchecked");
    rdc(ERRSTAT_ADDR, ZERO_BYTE, "zero parity no flag");
    set_mode(8'he4);
    for (int i = 1; i <= 18; i++)
      far.send(frame_of(8'(i), 8'he4, 1'b0), 32'(frameLen));
    repeat (3) @(negedge clock);
    rdc(ERRSTAT_ADDR, 8'h01, "overrun flag");
    rdc(RXHOLD_ADDR, 8'h01, "holding kept");
    wr(MODE_ADDR, 8'h80);
    wr(MODE_ADDR, 8'h00);
    rdc(RXHOLD_ADDR, HOLD_RESET, "holding reset by power");
    rdc(TXSTAT_ADDR, ZERO_BYTE, "tx status reset by power");
    d0 = doneCnt;
    far.send(12'h1ff, 32'(frameLen));
    repeat (3) @(negedge clock);
    check(12'(doneCnt - d0), 12'h000, "input ignored unpowered");
    check(12'(serialOut), 12'h001, "line high unpowered");
    final_report();
  end
endmodule
